// *** hdl/adcs_clk_div.sv ***
// Purpose: makes the converter clock as a one-cycle enable pulse
// Assumes: select codes 0..7 mean divide by 1..128
// Notes:   restart realigns the count so the first period is whole
`timescale 1ns/100ps
`default_nettype none
`include "adcs_params.svh"
module adcs_clk_div (
  input  wire logic clock,        // system clock
  input  wire logic rst_b,        // async reset, active low
  adcs_div_if.div   divPort       // select in, tick out
);
  import adcs_pkg::*;

  logic [`ADCS_DIV_W-1:0] cnt_r;
  logic [`ADCS_DIV_W-1:0] lastCount;

  // divide ratio
  // all-ones mask below the selected power of two
  assign lastCount = `ADCS_DIV_W'((8'h01 << divPort.divSel) - 8'h01);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (divPort.restart || cnt_r >= lastCount) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + `ADCS_DIV_W'(1);
    end
  end

  assign divPort.tick = !divPort.restart && (cnt_r >= lastCount);

endmodule : adcs_clk_div
`default_nettype wire

// *** hdl/adcs_div_if.sv ***
// Purpose: carries divider select, restart and tick between sequencer and divider
// Assumes: one clock domain
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
interface adcs_div_if;
  import adcs_pkg::*;
  adcs_div_sel_t divSel;
  logic          restart;
  logic          tick;
  modport ctrl (output divSel, output restart, input tick);
  modport div  (input divSel, input restart, output tick);
endinterface : adcs_div_if
`default_nettype wire

// *** hdl/adcs_params.svh ***
// Purpose: offsets, field positions and reset values of the converter sequencer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ADCS_OFF_CTRL_A      12'h000
`define ADCS_OFF_CTRL_B      12'h004
`define ADCS_OFF_CTRL_C      12'h008
`define ADCS_OFF_INT_CTRL    12'h00C
`define ADCS_OFF_RES_HIGH    12'h010
`define ADCS_OFF_RES_LOW     12'h014

// ****************************************
// control register a fields
// ****************************************
`define ADCS_A_START         7
`define ADCS_A_BUSY          6
`define ADCS_A_POWER         5
`define ADCS_A_FORMAT        4
`define ADCS_A_CHAN_HI       1
`define ADCS_A_CHAN_LO       0

// ****************************************
// control register b and c fields
// ****************************************
`define ADCS_B_SRC_HI        7
`define ADCS_B_SRC_LO        4
`define ADCS_B_DIV_HI        2
`define ADCS_B_DIV_LO        0
`define ADCS_C_AMP_EN        7
`define ADCS_C_AMP_IN        4
`define ADCS_C_REF_HI        3
`define ADCS_C_REF_LO        2
`define ADCS_C_GAIN_HI       1
`define ADCS_C_GAIN_LO       0

// ****************************************
// interrupt control fields
// ****************************************
`define ADCS_I_GLOBAL_EN     0
`define ADCS_I_CONV_EN       1
`define ADCS_I_FLAG          2

// ****************************************
// reset values and counts
// ****************************************
`define ADCS_RST_BYTE        8'h00
`define ADCS_RST_RESULT      12'h000
`define ADCS_SAR_FIRST       12'h800
`define ADCS_SAMPLE_CYCLES   4'h4
`define ADCS_CONVERT_CYCLES  4'hC
`define ADCS_TOP_BIT         4'hB
`define ADCS_DIV_W           7

`endif

// *** hdl/adcs_pkg.sv ***
// Purpose: types shared by the converter sequencer files
// Assumes: nothing
// Notes:   state codes walk idle, armed, sample, convert in gray order
package adcs_pkg;

  typedef enum logic [1:0] {
    ADCS_IDLE    = 2'b00,
    ADCS_ARMED   = 2'b01,
    ADCS_SAMPLE  = 2'b11,
    ADCS_CONVERT = 2'b10
  } adcs_state_t;

  typedef logic [2:0]  adcs_div_sel_t;
  typedef logic [11:0] adcs_result_t;

endpackage : adcs_pkg

// *** hdl/adcs_sequencer.sv ***
// Purpose: apb-controlled sequencer for one 12-bit successive-approximation converter
// Assumes: comparator output arrives asynchronously; dac and switches are analog-side
// Notes:   zero-wait apb slave; read data registered in the setup phase
//
// How it works
// - start bit pulsed low-high-low by software launches one conversion
// - busy flag set once a conversion is launched, held during it
// - busy flag cleared when the conversion finishes
// - completion sets interrupt flag; irq out if both enables set
// - three-bit select divides system clock by 1 to 128
// - analog powered only with power enable; software waits before starting
// - four converter clocks sampling, then twelve converting
// - source codes 0000, 0100, 11xx route the chosen external channel
// - codes 0x01, 0x10, 0x11 pick internal signal, external switched off
// - format bit arranges result in high and low result registers
// - result readable in high and low registers once busy drops
// - result is a 12-bit unsigned code, full scale 0FFF
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "adcs_params.svh"
module adcs_sequencer (
  input  wire logic                clock,           // system clock, 25 MHz
  input  wire logic                rst_b,           // async reset, active low
  input  wire logic                psel,            // apb select
  input  wire logic                penable,         // apb access phase
  input  wire logic                pwrite,          // apb write
  input  wire logic [11:0]         paddr,           // apb byte address
  input  wire logic [31:0]         pwdata,          // apb write data
  output logic                     pready,          // apb ready
  output logic [31:0]              prdata,          // apb read data
  output logic                     pslverr,         // apb error, unmapped address
  input  wire logic                compAbove,       // comparator: input above dac
  output logic                     analogPowerOn,   // converter analog power
  output logic                     sampleHold,      // sampling switch closed
  output adcs_pkg::adcs_result_t   dacCode,         // sar trial code
  output logic                     extConnect,      // external channel switch on
  output logic [1:0]               extChannel,      // external channel number
  output logic [3:0]               internalSource,  // internal source code, 0 if none
  output logic [1:0]               referenceSelect, // reference source select
  output logic                     ampEnable,       // reference gain amplifier on
  output logic                     ampInput,        // amplifier input select
  output logic [1:0]               ampGain,         // amplifier gain select
  output logic                     convIrq          // converter interrupt request
);
  import adcs_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  adcs_div_if divBus ();

  logic         startBit_r;
  logic         startPrev_r;
  logic         powerEn_r;
  logic         format_r;
  logic [1:0]   chan_r;
  logic [3:0]   srcSel_r;
  adcs_div_sel_t divSel_r;
  logic         ampEn_r;
  logic         ampIn_r;
  logic [1:0]   refSel_r;
  logic [1:0]   gain_r;
  logic         gie_r;
  logic         cie_r;
  logic         flag_r;
  logic         busy_r;
  adcs_state_t  state_r;
  adcs_state_t  state_nxt;
  logic [3:0]   cycCnt_r;
  logic [3:0]   bitIdx_r;
  adcs_result_t sar_r;
  adcs_result_t result_r;
  logic [31:0]  rdData_r;
  logic         err_r;
  logic         compS1_r;
  logic         compS2_r;
  logic         compS3_r;
  logic         compStable_r;
  logic         setupPh;
  logic         wrEn;
  logic         mapped;
  logic         startRise;
  logic         startFall;
  logic         convDone;
  logic         extCode;
  logic         intCode;
  logic [7:0]   resHigh;
  logic [7:0]   resLow;
  logic [31:0]  rdMux;

  // ****************************************
  // apb slave
  // ****************************************
  assign setupPh = psel && !penable;
  assign wrEn    = psel && penable && pwrite && !err_r;
  assign mapped  = (paddr == `ADCS_OFF_CTRL_A) || (paddr == `ADCS_OFF_CTRL_B) ||
                   (paddr == `ADCS_OFF_CTRL_C) || (paddr == `ADCS_OFF_INT_CTRL) ||
                   (paddr == `ADCS_OFF_RES_HIGH) || (paddr == `ADCS_OFF_RES_LOW);
  assign pready  = 1'b1;
  assign prdata  = rdData_r;
  assign pslverr = psel && penable && err_r;

  // result arrangement
  // format 0: left aligned; format 1: right aligned
  assign resHigh = format_r ? {4'h0, result_r[11:8]} : result_r[11:4];
  assign resLow  = format_r ? result_r[7:0] : {result_r[3:0], 4'h0};

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `ADCS_OFF_CTRL_A:   rdMux = {24'h00_0000, startBit_r, busy_r, powerEn_r, format_r, 2'b00, chan_r};
      `ADCS_OFF_CTRL_B:   rdMux = {24'h00_0000, srcSel_r, 1'b0, divSel_r};
      `ADCS_OFF_CTRL_C:   rdMux = {24'h00_0000, ampEn_r, 2'b00, ampIn_r, refSel_r, gain_r};
      `ADCS_OFF_INT_CTRL: rdMux = {29'h0000_0000, flag_r, cie_r, gie_r};
      `ADCS_OFF_RES_HIGH: rdMux = {24'h00_0000, resHigh};
      `ADCS_OFF_RES_LOW:  rdMux = {24'h00_0000, resLow};
      default:            rdMux = 32'h0000_0000;
    endcase
  end

  // read data and error captured in setup so the access phase answers at once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else if (setupPh) begin
      rdData_r <= pwrite ? 32'h0000_0000 : rdMux;
      err_r    <= !mapped;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      startBit_r <= 1'b0;
      powerEn_r  <= 1'b0;
      format_r   <= 1'b0;
      chan_r     <= 2'b00;
    end else if (wrEn && paddr == `ADCS_OFF_CTRL_A) begin
      startBit_r <= pwdata[`ADCS_A_START];
      powerEn_r  <= pwdata[`ADCS_A_POWER];
      format_r   <= pwdata[`ADCS_A_FORMAT];
      chan_r     <= pwdata[`ADCS_A_CHAN_HI:`ADCS_A_CHAN_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      srcSel_r <= 4'h0;
      divSel_r <= 3'h0;
    end else if (wrEn && paddr == `ADCS_OFF_CTRL_B) begin
      srcSel_r <= pwdata[`ADCS_B_SRC_HI:`ADCS_B_SRC_LO];
      divSel_r <= pwdata[`ADCS_B_DIV_HI:`ADCS_B_DIV_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ampEn_r  <= 1'b0;
      ampIn_r  <= 1'b0;
      refSel_r <= 2'b00;
      gain_r   <= 2'b00;
    end else if (wrEn && paddr == `ADCS_OFF_CTRL_C) begin
      ampEn_r  <= pwdata[`ADCS_C_AMP_EN];
      ampIn_r  <= pwdata[`ADCS_C_AMP_IN];
      refSel_r <= pwdata[`ADCS_C_REF_HI:`ADCS_C_REF_LO];
      gain_r   <= pwdata[`ADCS_C_GAIN_HI:`ADCS_C_GAIN_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gie_r <= 1'b0;
      cie_r <= 1'b0;
    end else if (wrEn && paddr == `ADCS_OFF_INT_CTRL) begin
      gie_r <= pwdata[`ADCS_I_GLOBAL_EN];
      cie_r <= pwdata[`ADCS_I_CONV_EN];
    end
  end

  // ****************************************
  // start edge detection
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= startBit_r;
    end
  end

  assign startRise = startBit_r && !startPrev_r;
  assign startFall = !startBit_r && startPrev_r;

  // ****************************************
  // comparator synchroniser
  // ****************************************
  // stage one is read only by stage two; stable value moves when stages 2 and 3 agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      compS1_r     <= 1'b0;
      compS2_r     <= 1'b0;
      compS3_r     <= 1'b0;
      compStable_r <= 1'b0;
    end else begin
      compS1_r <= compAbove;
      compS2_r <= compS1_r;
      compS3_r <= compS2_r;
      if (compS2_r == compS3_r) begin
        compStable_r <= compS3_r;
      end
    end
  end

  // ****************************************
  // converter clock divider
  // ****************************************
  assign divBus.divSel  = divSel_r;
  assign divBus.restart = (state_r == ADCS_ARMED) && startFall;

  adcs_clk_div uDiv (
    .clock   (clock),
    .rst_b   (rst_b),
    .divPort (divBus.div)
  );

  // ****************************************
  // sequencer state machine
  // ****************************************
  assign convDone = (state_r == ADCS_CONVERT) && divBus.tick && (bitIdx_r == 4'h0);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCS_IDLE: begin
        if (startRise) begin
          state_nxt = ADCS_ARMED;
        end
      end
      ADCS_ARMED: begin
        if (startFall) begin
          state_nxt = ADCS_SAMPLE;
        end
      end
      ADCS_SAMPLE: begin
        if (divBus.tick && cycCnt_r == `ADCS_SAMPLE_CYCLES - 4'h1) begin
          state_nxt = ADCS_CONVERT;
        end
      end
      ADCS_CONVERT: begin
        if (convDone) begin
          state_nxt = ADCS_IDLE;
        end
      end
      default: state_nxt = ADCS_IDLE;
    endcase
    if (startRise) begin
      state_nxt = ADCS_ARMED;
    end
    if (!powerEn_r) begin
      state_nxt = ADCS_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ADCS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cycCnt_r <= 4'h0;
    end else if (state_nxt != state_r) begin
      cycCnt_r <= 4'h0;
    end else if (state_r == ADCS_SAMPLE && divBus.tick) begin
      cycCnt_r <= cycCnt_r + 4'h1;
    end
  end

  // ****************************************
  // busy flag
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else if (!powerEn_r) begin
      busy_r <= 1'b0;
    end else if (state_nxt == ADCS_SAMPLE && state_r == ADCS_ARMED) begin
      busy_r <= 1'b1;
    end else if (convDone || startRise) begin
      busy_r <= 1'b0;
    end
  end

  // ****************************************
  // successive approximation
  // ****************************************
  // twelve conversion clocks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sar_r    <= `ADCS_RST_RESULT;
      bitIdx_r <= 4'h0;
    end else if (state_r == ADCS_SAMPLE && state_nxt == ADCS_CONVERT) begin
      sar_r    <= `ADCS_SAR_FIRST;
      bitIdx_r <= `ADCS_TOP_BIT;
    end else if (state_r == ADCS_CONVERT && state_nxt == ADCS_CONVERT && divBus.tick) begin
      sar_r[bitIdx_r] <= compStable_r;
      sar_r[bitIdx_r - 4'h1] <= 1'b1;
      bitIdx_r <= bitIdx_r - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= `ADCS_RST_RESULT;
    end else if (convDone && powerEn_r && !startRise) begin
      result_r <= {sar_r[11:1], compStable_r};
    end
  end

  // ****************************************
  // interrupt request flag
  // ****************************************
  // flag on completion
  // set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (convDone && powerEn_r && !startRise) begin
      flag_r <= 1'b1;
    end else if (wrEn && paddr == `ADCS_OFF_INT_CTRL && !pwdata[`ADCS_I_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      convIrq <= 1'b0;
    end else begin
      convIrq <= flag_r && gie_r && cie_r;
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  // external source codes
  assign extCode = (srcSel_r == 4'h0) || (srcSel_r == 4'h4) || (srcSel_r[3:2] == 2'b11);
  assign intCode = !srcSel_r[3] && (srcSel_r[1:0] != 2'b00);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      analogPowerOn   <= 1'b0;
      sampleHold      <= 1'b0;
      dacCode         <= `ADCS_RST_RESULT;
      extConnect      <= 1'b0;
      extChannel      <= 2'b00;
      internalSource  <= 4'h0;
      referenceSelect <= 2'b00;
      ampEnable       <= 1'b0;
      ampInput        <= 1'b0;
      ampGain         <= 2'b00;
    end else begin
      analogPowerOn   <= powerEn_r;
      sampleHold      <= (state_r == ADCS_SAMPLE);
      dacCode         <= sar_r;
      extConnect      <= powerEn_r && extCode;
      extChannel      <= chan_r;
      internalSource  <= (powerEn_r && intCode) ? srcSel_r : 4'h0;
      referenceSelect <= refSel_r;
      ampEnable       <= ampEn_r;
      ampInput        <= ampIn_r;
      ampGain         <= gain_r;
    end
  end

endmodule : adcs_sequencer
`default_nettype wire

// *** tb/adcs_sequencer_asserts.sv ***
// Purpose: port-level checks of the converter sequencer
// Assumes: apb writes are mirrored here for divider, source and enables
// Notes:   sampling length holds only when no restart hits sampling
`timescale 1ns/100ps
`default_nettype none
module adcs_sequencer_asserts (
  input wire logic                   clock,           // system clock
  input wire logic                   rst_b,           // async reset
  input wire logic                   psel,            // apb
  input wire logic                   penable,         // apb
  input wire logic                   pwrite,          // apb
  input wire logic [11:0]            paddr,           // apb
  input wire logic [31:0]            pwdata,          // apb
  input wire logic                   pready,          // apb
  input wire logic [31:0]            prdata,          // apb
  input wire logic                   pslverr,         // apb
  input wire logic                   compAbove,       // comparator
  input wire logic                   analogPowerOn,   // power
  input wire logic                   sampleHold,      // sampling
  input wire adcs_pkg::adcs_result_t dacCode,         // trial code
  input wire logic                   extConnect,      // ext switch
  input wire logic [1:0]             extChannel,      // ext channel
  input wire logic [3:0]             internalSource,  // int source
  input wire logic [1:0]             referenceSelect, // reference
  input wire logic                   ampEnable,       // amplifier
  input wire logic                   ampInput,        // amp input
  input wire logic [1:0]             ampGain,         // amp gain
  input wire logic                   convIrq          // irq
);
  import adcs_pkg::*;
  logic [2:0]  divSel;
  logic [3:0]  srcSel;
  logic        gEn;
  logic        cEn;
  logic [11:0] sampleLen;
  wire         wrAcc = psel && penable && pwrite && pready;

  // ****************************************
  // mirrors of software settings
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divSel <= 3'h0;
      srcSel <= 4'h0;
      gEn    <= 1'b0;
      cEn    <= 1'b0;
    end else if (wrAcc && paddr == 12'h004) begin
      divSel <= pwdata[2:0];
      srcSel <= pwdata[7:4];
    end else if (wrAcc && paddr == 12'h00C) begin
      gEn <= pwdata[0];
      cEn <= pwdata[1];
    end
  end

  // counter, since sampling can span 512 cycles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      sampleLen <= 12'h000;
    else if (!sampleHold)
      sampleLen <= 12'h000;
    else
      sampleLen <= sampleLen + 12'h001;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence powerOffSeq;
    !analogPowerOn [*3];
  endsequence

  chk_sample_len: assert property ($fell(sampleHold) |-> sampleLen == (12'h004 << divSel))
    else $error("sampling length wrong for divider");
  chk_sample_min: assert property ($rose(sampleHold) |-> sampleHold [*4])
    else $error("sampling shorter than four ticks");
  chk_sample_power: assert property ($rose(sampleHold) |-> analogPowerOn)
    else $error("sampling started unpowered");
  chk_idle_unpowered: assert property (powerOffSeq |-> !sampleHold)
    else $error("sequencer active while unpowered");
  chk_ext_exclusive: assert property (extConnect |-> internalSource == 4'h0)
    else $error("external and internal source together");
  chk_internal_codes: assert property (internalSource != 4'h0 |-> internalSource inside {1, 2, 3, 5, 6, 7})
    else $error("internal source code not internal");
  chk_ext_route: assert property ($rose(extConnect) |-> srcSel inside {0, 4, 12, 13, 14, 15})
    else $error("external channel on for internal code");
  chk_irq_enables: assert property ($rose(convIrq) |-> gEn && cEn)
    else $error("interrupt raised while disabled");
endmodule : adcs_sequencer_asserts

bind adcs_sequencer adcs_sequencer_asserts adcs_sequencer_asserts_inst (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .compAbove(compAbove),
  .analogPowerOn(analogPowerOn), .sampleHold(sampleHold), .dacCode(dacCode), .extConnect(extConnect),
  .extChannel(extChannel), .internalSource(internalSource), .referenceSelect(referenceSelect),
  .ampEnable(ampEnable), .ampInput(ampInput), .ampGain(ampGain), .convIrq(convIrq));
`default_nettype wire

// *** tb/adcs_sequencer_tb_top.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: zero-wait apb slave, 25 MHz clock
// Notes:   comparator held steady per run, so results are all ones or zeros
`timescale 1ns/100ps
`default_nettype none
`include "adcs_params.svh"
module adcs_sequencer_tb_top;
  import adcs_pkg::*;
  logic         clock, rst_b, psel, penable, pwrite, pready, pslverr, compAbove;
  logic         analogPowerOn, sampleHold, extConnect, ampEnable, ampInput, convIrq, rerr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdat;
  logic [1:0]   extChannel, referenceSelect, ampGain;
  logic [3:0]   internalSource;
  adcs_result_t dacCode;
  int           nFail = 0;
  int           totalChecks = 0;
  int           cyc = 0;

  adcs_sequencer adcs_sequencer_inst (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .compAbove(compAbove), .analogPowerOn(analogPowerOn), .sampleHold(sampleHold),
    .dacCode(dacCode), .extConnect(extConnect), .extChannel(extChannel),
    .internalSource(internalSource), .referenceSelect(referenceSelect), .ampEnable(ampEnable),
    .ampInput(ampInput), .ampGain(ampGain), .convIrq(convIrq));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up;
    if (nFail == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", 32'h1, {31'h0, pready});
      wrap_up();
    end
  endtask : apb

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rdat);
  endtask : rd_chk

  // launch with a start pulse, then poll busy until it drops
  task automatic convert(input logic [7:0] cfg, output int span);
    int t0;
    int k;
    apb(1'b1, `ADCS_OFF_CTRL_A, {24'h0, cfg | 8'h80});
    apb(1'b1, `ADCS_OFF_CTRL_A, {24'h0, cfg});
    t0 = cyc;
    rd_chk("busySet", `ADCS_OFF_CTRL_A, {24'h0, cfg | 8'h40});
    for (k = 0; k < 1200 && rdat[6] === 1'b1; k++)
      apb(1'b0, `ADCS_OFF_CTRL_A, 32'h0);
    span = cyc - t0;
    check("busyClear", 32'h0, {31'h0, rdat[6]});
    if (rdat[6] !== 1'b0)
      wrap_up();
  endtask : convert

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    int i;
    for (i = 0; i < 6; i++)
      rd_chk("resetVal", 12'(4 * i), 32'h0);
    apb(1'b1, `ADCS_OFF_RES_HIGH, 32'hFF);
    rd_chk("resultRo", `ADCS_OFF_RES_HIGH, 32'h0);
    check("mappedErr", 32'h0, {31'h0, rerr});
    rd_chk("unmappedData", 12'h018, 32'h0);
    check("unmappedErr", 32'h1, {31'h0, rerr});
  endtask : test_reset

  task automatic test_routing;
    int s;
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'h22);
    apb(1'b1, `ADCS_OFF_CTRL_C, 32'h9E);
    for (s = 0; s < 16; s++) begin
      apb(1'b1, `ADCS_OFF_CTRL_B, {24'h0, 4'(s), 4'h0});
      repeat (3) @(posedge clock);
      check("extConnect", {31'h0, s == 0 || s == 4 || s >= 12}, {31'h0, extConnect});
      check("intSource", (s[1:0] != 0 && s < 8) ? 32'(s) : 32'h0, {28'h0, internalSource});
    end
    check("extChannel", 32'h2, {30'h0, extChannel});
    check("refCfg", 32'h3E, {26'h0, ampEnable, ampInput, referenceSelect, ampGain});
  endtask : test_routing

  task automatic test_divider;
    int          s;
    int          span;
    logic [11:0] res;
    for (s = 0; s < 8; s++) begin
      compAbove <= s[1];
      res = s[1] ? 12'hFFF : 12'h000;
      apb(1'b1, `ADCS_OFF_CTRL_B, 32'(s));
      convert({3'b001, s[0], 4'h0}, span);
      check("convTime", 32'h1, {31'h0, span >= (16 << s) && span <= (16 << s) + 12});
      rd_chk("resHigh", `ADCS_OFF_RES_HIGH, s[0] ? {28'h0, res[11:8]} : {24'h0, res[11:4]});
      rd_chk("resLow", `ADCS_OFF_RES_LOW, s[0] ? {24'h0, res[7:0]} : {24'h0, res[3:0], 4'h0});
      check("dacCode", {20'h0, s[1] ? 12'hFFF : 12'h001}, {20'h0, dacCode});
    end
  endtask : test_divider

  task automatic test_irq;
    int span;
    apb(1'b1, `ADCS_OFF_CTRL_B, 32'h4);
    apb(1'b1, `ADCS_OFF_INT_CTRL, 32'h3);
    convert(8'h20, span);
    repeat (2) @(posedge clock);
    check("irqRaised", 32'h1, {31'h0, convIrq});
    apb(1'b1, `ADCS_OFF_INT_CTRL, 32'h3);
    repeat (2) @(posedge clock);
    check("irqCleared", 32'h0, {31'h0, convIrq});
    apb(1'b1, `ADCS_OFF_INT_CTRL, 32'h1);
    convert(8'h20, span);
    rd_chk("flagPolled", `ADCS_OFF_INT_CTRL, 32'h5);
    check("irqMasked", 32'h0, {31'h0, convIrq});
    apb(1'b1, `ADCS_OFF_INT_CTRL, 32'h0);
  endtask : test_irq

  task automatic test_abort;
    int span;
    apb(1'b1, `ADCS_OFF_CTRL_B, 32'h2);
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'hA0);
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'h20);
    repeat (40) @(posedge clock);
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'hA0);
    apb(1'b0, `ADCS_OFF_CTRL_A, 32'h0);
    check("abortBusy", 32'h0, {31'h0, rdat[6]});
    rd_chk("abortFlag", `ADCS_OFF_INT_CTRL, 32'h0);
    convert(8'h20, span);
    check("restartTime", 32'h1, {31'h0, span >= 64 && span <= 76});
  endtask : test_abort

  task automatic test_power_off;
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'h00);
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'h80);
    apb(1'b1, `ADCS_OFF_CTRL_A, 32'h00);
    apb(1'b0, `ADCS_OFF_CTRL_A, 32'h0);
    check("offBusy", 32'h0, {31'h0, rdat[6]});
    check("offPower", 32'h0, {31'h0, analogPowerOn});
  endtask : test_power_off

  initial begin
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    compAbove = 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    test_reset();
    test_routing();
    test_divider();
    test_irq();
    test_abort();
    test_power_off();
    wrap_up();
  end
endmodule : adcs_sequencer_tb_top
`default_nettype wire
